// *** inc/vsir_pkg.sv ***
// constants and types shared by the partition init/release logic
package vsir_pkg;

  localparam int NUM_PART = 4;

  // register offsets
  localparam logic [11:0] MPC_OFF = 12'h354;
  localparam logic [11:0] PEN_OFF = 12'h358;
  localparam logic [11:0] PUS_BASE = 12'h360;
  localparam logic [11:0] PUS_LAST = 12'h36C;
  localparam logic [11:0] PPM_BASE = 12'h380;
  localparam logic [11:0] PPM_LAST = 12'h38C;
  localparam logic [11:0] REL_OFF = 12'h3AC;

  // management port control fields
  localparam int MPC_ACT_EN_BIT = 5;
  localparam int MPC_RED_EN_BIT = 13;
  localparam int MPC_ACT_HI_BIT = 4;
  localparam int MPC_RED_HI_BIT = 12;
  localparam int MPC_RED_LO_POS = 8;
  localparam int REL_BIT = 0;

  // writable bits: ports reach only the RW bits, loaders also the RO ones
  localparam logic [31:0] MPC_PORT_MASK = 32'h0000_3777;
  localparam logic [31:0] MPC_LOAD_MASK = 32'h0000_F777;
  localparam logic [31:0] MPC_RO_MASK = 32'h0000_C000;
  localparam logic [31:0] PEN_MASK = 32'h0000_000F;
  localparam logic [31:0] PUS_MASK = 32'h0000_0017;
  localparam logic [31:0] PPM_MASK = 32'h00FF_000F;

  // reset values
  localparam logic [31:0] MPC_RESET = 32'h0000_0000;
  localparam logic [31:0] PEN_RESET = 32'h0000_0000;
  localparam logic [31:0] PUS_RESET = 32'h0000_0000;
  localparam logic [31:0] PPM_RESET = 32'h0000_0000;

  // i2c slave write time at the clock rate
  localparam int CLK_PERIOD_NS = 8;
  localparam int I2C_MAX_KHZ = 100;
  localparam int I2C_PERIOD_NS = 1000000 / I2C_MAX_KHZ;
  localparam int I2C_CLOCKS_PER_WRITE = 83;
  localparam int I2C_WRITE_NS = I2C_PERIOD_NS * I2C_CLOCKS_PER_WRITE;
  localparam int I2C_WRITE_CYCLES =
    (I2C_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // which agent issues a register access
  typedef enum logic [1:0] {
    SRC_EEPROM,
    SRC_I2C,
    SRC_PORT,
    SRC_NONE
  } vsir_src_t;

endpackage : vsir_pkg

// *** core/vsir_part_entry.sv ***
// one partition table entry: upstream select, port mask and host view
`timescale 1ns/1ps
module vsir_part_entry (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic wr_upstream_in,
  input wire logic wr_mask_in,
  input wire logic [31:0] wdata_in,
  input wire logic show_in,
  output logic [31:0] upstream_out,
  output logic [31:0] mask_out,
  output logic [31:0] view_upstream_out,
  output logic [31:0] view_mask_out
);

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      upstream_out <= vsir_pkg::PUS_RESET;
    end else if (wr_upstream_in) begin
      upstream_out <= wdata_in & vsir_pkg::PUS_MASK;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      mask_out <= vsir_pkg::PPM_RESET;
    end else if (wr_mask_in) begin
      mask_out <= wdata_in & vsir_pkg::PPM_MASK;
    end
  end

  // a host sees its own ports only once released and enabled
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      view_upstream_out <= 32'h0000_0000;
      view_mask_out <= 32'h0000_0000;
    end else begin
      view_upstream_out <= show_in ? upstream_out : 32'h0000_0000;
      view_mask_out <= show_in ? mask_out : 32'h0000_0000;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  chk_view_hidden: assert property (!show_in |=> view_mask_out == 0)
    else $error("hidden partition shows ports");
  chk_mask_write: assert property (wr_mask_in |=>
    mask_out == ($past(wdata_in) & vsir_pkg::PPM_MASK))
    else $error("port mask write lost");

endmodule : vsir_part_entry

// *** core/vsir_top.sv ***
// partition init sequencer, strap latch, release hold and partition table
//
// Operation
// - i2c writes spaced by 83 bus clocks
// - eeprom first, then i2c, then management port
// - release bit lets held links train
// - i2c strap low: hold until i2c releases
// - i2c strap high: no wait on i2c
// - option one: management port trains first
// - option two: all ports train after eeprom
// - nonzero mode straps select partition mode
// - strapped mode can never be changed
// - partition table writable in partition mode
// - of the ports, only the active management port reaches table
// - management control survives hot reset
// - partition enable resets from mode straps
// - one upstream select per partition
// - released hosts see only own ports
// - loaders write read-only bits, ports cannot
// - control names active and redundant port
// - active enable resets to inverted strap
`timescale 1ns/1ps
module vsir_top #(
  parameter int I2C_WRITE_CYCLES = vsir_pkg::I2C_WRITE_CYCLES
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic hot_rst_in,
  input wire logic [1:0] switch_mode_straps_in,
  input wire logic mgmt_port_enable_strap_n_in,
  input wire logic bringup_option_strap_in,
  input wire logic i2c_cfg_strap_n_in,
  input wire logic [3:0] mgmt_port_sel_straps_in,
  input wire logic eeprom_done_in,
  input wire logic cfg_req_in,
  input wire logic cfg_wr_in,
  input wire logic [1:0] cfg_src_in,
  input wire logic [3:0] cfg_port_in,
  input wire logic [11:0] cfg_addr_in,
  input wire logic [31:0] cfg_wdata_in,
  output logic cfg_ack_out,
  output logic cfg_refused_out,
  output logic [31:0] cfg_rdata_out,
  output logic vs_mode_out,
  output logic released_out,
  output logic mgmt_train_en_out,
  output logic link_train_en_out,
  output logic [3:0] part_active_out,
  output logic [vsir_pkg::NUM_PART*32-1:0] part_upstream_out,
  output logic [vsir_pkg::NUM_PART*32-1:0] part_mask_out
);

  typedef enum logic [2:0] {
    ST_LATCH,
    ST_EEPROM,
    ST_I2C,
    ST_MGMT,
    ST_RELEASED
  } vsir_state_t;

  vsir_state_t state;
  vsir_state_t next_state;
  vsir_pkg::vsir_src_t src;
  logic i2c_cfg_n;
  logic bringup_opt;
  logic [31:0] mpc;
  logic [31:0] pen;
  logic [31:0] i2c_gap;
  logic [31:0] up_q [vsir_pkg::NUM_PART];
  logic [31:0] mask_q [vsir_pkg::NUM_PART];
  logic hit_mpc, hit_pen, hit_pus, hit_ppm, hit_rel;
  logic [1:0] pidx;
  logic [3:0] act_port, red_port;
  logic from_act, from_red, loader;
  logic acc_ok, tbl_lock, acc, wr, wr_mpc, rel_set;
  logic [31:0] mpc_mask;
  logic [31:0] rd;

  function automatic logic [3:0] pen_from_strap(input logic [1:0] s);
    case (s)
      2'h0: return 4'h1;
      2'h1: return 4'h3;
      2'h2: return 4'h7;
      default: return 4'hF;
    endcase
  endfunction : pen_from_strap

  assign src = vsir_pkg::vsir_src_t'(cfg_src_in);
  assign loader = (src == vsir_pkg::SRC_EEPROM) || (src == vsir_pkg::SRC_I2C);

  // address decode
  assign hit_mpc = cfg_addr_in == vsir_pkg::MPC_OFF;
  assign hit_pen = cfg_addr_in == vsir_pkg::PEN_OFF;
  assign hit_rel = cfg_addr_in == vsir_pkg::REL_OFF;
  assign hit_pus = cfg_addr_in >= vsir_pkg::PUS_BASE &&
    cfg_addr_in <= vsir_pkg::PUS_LAST && cfg_addr_in[1:0] == 2'h0;
  assign hit_ppm = cfg_addr_in >= vsir_pkg::PPM_BASE &&
    cfg_addr_in <= vsir_pkg::PPM_LAST && cfg_addr_in[1:0] == 2'h0;
  assign pidx = cfg_addr_in[3:2];

  // port identity from the management control register
  assign act_port = {mpc[vsir_pkg::MPC_ACT_HI_BIT], mpc[2:0]};
  assign red_port = {mpc[vsir_pkg::MPC_RED_HI_BIT],
    mpc[vsir_pkg::MPC_RED_LO_POS+2:vsir_pkg::MPC_RED_LO_POS]};
  assign from_act = src == vsir_pkg::SRC_PORT &&
    mpc[vsir_pkg::MPC_ACT_EN_BIT] && cfg_port_in == act_port;
  assign from_red = src == vsir_pkg::SRC_PORT &&
    mpc[vsir_pkg::MPC_RED_EN_BIT] && cfg_port_in == red_port;

  // who may reach what, in which phase of bring-up
  always_comb begin
    acc_ok = 1'b0;
    if (src == vsir_pkg::SRC_EEPROM) begin
      acc_ok = state == ST_EEPROM;
    end else if (src == vsir_pkg::SRC_I2C) begin
      acc_ok = i2c_gap == 32'h0000_0000 &&
        ((!i2c_cfg_n && (state == ST_I2C || state == ST_MGMT)) ||
        state == ST_RELEASED);
    end else if (src == vsir_pkg::SRC_PORT) begin
      if (state != ST_MGMT && state != ST_RELEASED) begin
        acc_ok = 1'b0;
      end else if (hit_mpc) begin
        acc_ok = from_act || from_red;
      end else if (hit_pen || hit_pus || hit_ppm || hit_rel) begin
        acc_ok = from_act;
      end else begin
        acc_ok = 1'b1;
      end
    end
  end

  // the table is frozen outside partition mode
  assign tbl_lock = !vs_mode_out && cfg_wr_in &&
    (hit_pen || hit_pus || hit_ppm);
  assign acc = cfg_req_in && acc_ok && !tbl_lock;
  assign wr = acc && cfg_wr_in;
  assign wr_mpc = wr && hit_mpc;
  assign mpc_mask = loader ? vsir_pkg::MPC_LOAD_MASK :
    vsir_pkg::MPC_PORT_MASK;

  // in the i2c phase only the i2c master, in the management phase the port or the i2c master, may lift the hold, and only with a 1
  assign rel_set = wr && hit_rel && cfg_wdata_in[vsir_pkg::REL_BIT] &&
    ((state == ST_I2C && src == vsir_pkg::SRC_I2C) ||
    (state == ST_MGMT && src != vsir_pkg::SRC_EEPROM));

  always_comb begin
    next_state = state;
    case (state)
      ST_LATCH: next_state = ST_EEPROM;
      ST_EEPROM: begin
        if (eeprom_done_in) begin
          if (!i2c_cfg_n) begin
            next_state = ST_I2C;
          end else if (mpc[vsir_pkg::MPC_ACT_EN_BIT] && !bringup_opt) begin
            next_state = ST_MGMT;
          end else begin
            next_state = ST_RELEASED;
          end
        end
      end
      ST_I2C: begin
        if (rel_set) begin
          next_state = (mpc[vsir_pkg::MPC_ACT_EN_BIT] && !bringup_opt) ?
            ST_MGMT : ST_RELEASED;
        end
      end
      ST_MGMT: begin
        if (rel_set) begin
          next_state = ST_RELEASED;
        end
      end
      default: next_state = ST_RELEASED;
    endcase
  end

  // hot reset reruns the load sequence but keeps the straps and sticky bits
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state <= ST_LATCH;
    end else if (hot_rst_in) begin
      state <= ST_EEPROM;
    end else begin
      state <= next_state;
    end
  end

  // straps are caught once, on the first edge after fundamental reset
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      vs_mode_out <= 1'b0;
      i2c_cfg_n <= 1'b1;
      bringup_opt <= 1'b0;
    end else if (state == ST_LATCH) begin
      vs_mode_out <= switch_mode_straps_in != 2'h0;
      i2c_cfg_n <= i2c_cfg_strap_n_in;
      bringup_opt <= bringup_option_strap_in;
    end
  end

  // sticky: no hot reset term here
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      mpc <= vsir_pkg::MPC_RESET;
    end else if (state == ST_LATCH) begin
      mpc <= {18'h0, 8'h00, !mgmt_port_enable_strap_n_in,
        mgmt_port_sel_straps_in[3], 1'b0, mgmt_port_sel_straps_in[2:0]};
    end else if (wr_mpc) begin
      mpc <= (mpc & ~mpc_mask) | (cfg_wdata_in & mpc_mask);
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pen <= vsir_pkg::PEN_RESET;
    end else if (state == ST_LATCH) begin
      pen <= {28'h0, pen_from_strap(switch_mode_straps_in)};
    end else if (wr && hit_pen) begin
      pen <= cfg_wdata_in & vsir_pkg::PEN_MASK;
    end
  end

  // the slave cannot take a new access before the last one could finish
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      i2c_gap <= 32'h0000_0000;
    end else if (acc && src == vsir_pkg::SRC_I2C) begin
      i2c_gap <= 32'(I2C_WRITE_CYCLES - 1);
    end else if (i2c_gap != 32'h0000_0000) begin
      i2c_gap <= i2c_gap - 32'h0000_0001;
    end
  end

  always_comb begin
    rd = 32'h0000_0000;
    if (hit_mpc) begin
      rd = mpc;
    end else if (hit_pen) begin
      rd = pen;
    end else if (hit_pus) begin
      rd = up_q[pidx];
    end else if (hit_ppm) begin
      rd = mask_q[pidx];
    end else if (hit_rel) begin
      rd = {31'h0, state == ST_RELEASED};
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cfg_ack_out <= 1'b0;
      cfg_refused_out <= 1'b0;
      cfg_rdata_out <= 32'h0000_0000;
    end else begin
      cfg_ack_out <= acc;
      cfg_refused_out <= cfg_req_in && !acc;
      cfg_rdata_out <= (acc && !cfg_wr_in) ? rd : 32'h0000_0000;
    end
  end

  // link training gates
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || hot_rst_in) begin
      mgmt_train_en_out <= 1'b0;
      link_train_en_out <= 1'b0;
      released_out <= 1'b0;
      part_active_out <= 4'h0;
    end else begin
      mgmt_train_en_out <= state == ST_MGMT || state == ST_RELEASED;
      link_train_en_out <= state == ST_RELEASED;
      released_out <= state == ST_RELEASED;
      part_active_out <= (state == ST_RELEASED) ? pen[3:0] : 4'h0;
    end
  end

  for (genvar i = 0; i < vsir_pkg::NUM_PART; i++) begin : g_part
    vsir_part_entry i_vsir_part_entry (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .wr_upstream_in(wr && hit_pus && pidx == 2'(i)),
      .wr_mask_in(wr && hit_ppm && pidx == 2'(i)),
      .wdata_in(cfg_wdata_in),
      .show_in(state == ST_RELEASED && pen[i]),
      .upstream_out(up_q[i]),
      .mask_out(mask_q[i]),
      .view_upstream_out(part_upstream_out[i*32 +: 32]),
      .view_mask_out(part_mask_out[i*32 +: 32])
    );
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_eeprom_opt2;
    state == ST_EEPROM && eeprom_done_in && i2c_cfg_n && bringup_opt &&
      !hot_rst_in;
  endsequence

  sequence s_zero_release;
    state == ST_MGMT && wr && hit_rel && !cfg_wdata_in[0] && !hot_rst_in;
  endsequence

  chk_i2c_spacing: assert property (acc && src == vsir_pkg::SRC_I2C
    |=> i2c_gap == 32'(I2C_WRITE_CYCLES - 1))
    else $error("i2c spacing not armed");
  chk_eeprom_first: assert property (state == ST_EEPROM && cfg_req_in &&
    src == vsir_pkg::SRC_PORT |=> cfg_refused_out)
    else $error("port access during eeprom phase");
  chk_hold_links: assert property (state != ST_RELEASED |=>
    !link_train_en_out)
    else $error("links train before release");
  chk_i2c_hold: assert property (state == ST_EEPROM && eeprom_done_in &&
    !i2c_cfg_n && !hot_rst_in |=> state == ST_I2C ##1 !link_train_en_out)
    else $error("i2c hold not entered");
  chk_i2c_unused: assert property (i2c_cfg_n && state != ST_RELEASED &&
    cfg_req_in && src == vsir_pkg::SRC_I2C |=> cfg_refused_out)
    else $error("i2c accepted while not used");
  chk_mgmt_first: assert property (state == ST_MGMT && !hot_rst_in |=>
    mgmt_train_en_out && !link_train_en_out)
    else $error("management port not trained first");
  chk_all_train: assert property (s_eeprom_opt2 |=>
    state == ST_RELEASED ##1 link_train_en_out)
    else $error("option two did not release");
  chk_mode_fixed: assert property (state != ST_LATCH |=>
    $stable(vs_mode_out))
    else $error("strapped mode changed");
  chk_table_owner: assert property (cfg_req_in &&
    src == vsir_pkg::SRC_PORT && hit_pen && !from_act |=> cfg_refused_out)
    else $error("non-management port reached table");
  chk_mpc_sticky: assert property (hot_rst_in |=>
    mpc == $past(mpc))
    else $error("sticky control lost on hot reset");
  chk_strap_image: assert property (state == ST_LATCH |=>
    pen[3:0] == pen_from_strap($past(switch_mode_straps_in)) &&
    mpc[5] == !$past(mgmt_port_enable_strap_n_in))
    else $error("strap image not loaded");
  chk_ro_bits: assert property (cfg_req_in && cfg_wr_in &&
    src == vsir_pkg::SRC_PORT && hit_mpc |=> $stable(mpc[15:14]))
    else $error("port changed read-only bits");
  chk_zero_write: assert property (s_zero_release |=>
    state == ST_MGMT)
    else $error("zero write lifted the hold");

endmodule : vsir_top

// *** tb/vsir_agent.sv ***
// access agent standing for the loader, the i2c master and the host
`timescale 1ns/1ps
module vsir_agent #(
  parameter int GAP = 20
) (
  input wire logic clk_in,
  input wire logic ack_in,
  input wire logic refused_in,
  input wire logic [31:0] rdata_in,
  output logic eeprom_done_out,
  output logic req_out,
  output logic wr_out,
  output logic [1:0] src_out,
  output logic [3:0] port_out,
  output logic [11:0] addr_out,
  output logic [31:0] wdata_out
);
  initial begin
    eeprom_done_out = 1'h0;
    req_out = 1'h0;
    wr_out = 1'h0;
    src_out = 2'h3;
    port_out = 4'h0;
    addr_out = 12'h000;
    wdata_out = 32'h0000_0000;
  end

  // qualifiers are inverted once the pulse is gone, so late sampling
  // inside the design shows up as wrong data instead of passing
  task automatic access(input logic [1:0] s, input logic [3:0] p,
      input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [1:0] resp, output logic [31:0] rdata);
    req_out = 1'h1;
    wr_out = w;
    src_out = s;
    port_out = p;
    addr_out = a;
    wdata_out = d;
    @(negedge clk_in);
    req_out = 1'h0;
    wr_out = ~w;
    src_out = ~s;
    port_out = ~p;
    addr_out = ~a;
    wdata_out = ~d;
    resp = 2'h0;
    rdata = 32'h0000_0000;
    for (int n = 0; n < 3; n++) begin
      if (resp == 2'h0 && (ack_in === 1'h1 || refused_in === 1'h1)) begin
        resp = {ack_in, refused_in};
        rdata = rdata_in;
      end
      if (resp == 2'h0) @(negedge clk_in);
    end
    // one idle cycle, so a following call never re-raises req in this step
    @(negedge clk_in);
  endtask : access

  // a well-behaved master leaves a full slave-write time between accesses
  task automatic wait_gap();
    repeat (GAP + 2) @(negedge clk_in);
  endtask : wait_gap

  task automatic set_done(input logic v);
    eeprom_done_out = v;
  endtask : set_done
endmodule : vsir_agent

// *** tb/virtual_switch_init_release_bench.sv ***
// self-checking bench for the partition init and release sequencer
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    checks++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("Error at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module virtual_switch_init_release_bench;
  localparam int GAP = 20;
  localparam logic [1:0] EE = 2'h0;
  localparam logic [1:0] I2C = 2'h1;
  localparam logic [1:0] HOST = 2'h2;
  localparam logic [1:0] ACK = 2'h2;
  localparam logic [1:0] REF = 2'h1;
  localparam logic [11:0] MPC = vsir_pkg::MPC_OFF;
  localparam logic [11:0] PEN = vsir_pkg::PEN_OFF;
  localparam logic [11:0] REL = vsir_pkg::REL_OFF;
  logic clk_in, sys_rst_in, hot_rst_in, en_n, opt, i2c_n;
  logic [1:0] mode;
  logic [3:0] sel;
  logic eeprom_done, req, wr, ack, refused;
  logic [1:0] src, resp;
  logic [3:0] port, part_active;
  logic [11:0] addr;
  logic [31:0] wdata, rdata, rd;
  logic vs_mode, released, mgmt_train, link_train;
  logic [127:0] part_up, part_mask;
  int fails = 0;
  int checks = 0;
  int cycles = 0;

  vsir_top #(.I2C_WRITE_CYCLES(GAP)) i_vsir_top (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .hot_rst_in(hot_rst_in),
    .switch_mode_straps_in(mode), .mgmt_port_enable_strap_n_in(en_n),
    .bringup_option_strap_in(opt), .i2c_cfg_strap_n_in(i2c_n),
    .mgmt_port_sel_straps_in(sel), .eeprom_done_in(eeprom_done),
    .cfg_req_in(req), .cfg_wr_in(wr), .cfg_src_in(src),
    .cfg_port_in(port), .cfg_addr_in(addr), .cfg_wdata_in(wdata),
    .cfg_ack_out(ack), .cfg_refused_out(refused), .cfg_rdata_out(rdata),
    .vs_mode_out(vs_mode), .released_out(released),
    .mgmt_train_en_out(mgmt_train), .link_train_en_out(link_train),
    .part_active_out(part_active), .part_upstream_out(part_up),
    .part_mask_out(part_mask));

  vsir_agent #(.GAP(GAP)) i_vsir_agent (
    .clk_in(clk_in), .ack_in(ack), .refused_in(refused),
    .rdata_in(rdata), .eeprom_done_out(eeprom_done), .req_out(req),
    .wr_out(wr), .src_out(src), .port_out(port), .addr_out(addr),
    .wdata_out(wdata));

  initial begin
    clk_in = 1'h0;
    forever #4 clk_in = ~clk_in;
  end

  task automatic give_verdict();
    if (fails == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  // a hang would otherwise never reach the verdict
  always @(posedge clk_in) begin
    cycles++;
    if (cycles > 3000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic acc(input logic [1:0] s, input logic [3:0] p,
      input logic w, input logic [11:0] a, input logic [31:0] d);
    i_vsir_agent.access(s, p, w, a, d, resp, rd);
  endtask : acc

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask : cyc

  task automatic do_reset(input logic [1:0] m, input logic e,
      input logic o, input logic i, input logic [3:0] s);
    mode = m;
    en_n = e;
    opt = o;
    i2c_n = i;
    sel = s;
    sys_rst_in = 1'h1;
    i_vsir_agent.set_done(1'h0);
    cyc(16);
    sys_rst_in = 1'h0;
    cyc(2);
  endtask : do_reset

  task automatic t_straps();
    `CHK(vs_mode, 1'h1)
    acc(EE, 4'h0, 1'h0, MPC, 32'h0);
    `CHK(rd, 32'h0000_0033)
    acc(EE, 4'h0, 1'h0, PEN, 32'h0);
    `CHK(rd, 32'h0000_0007)
    `CHK(link_train, 1'h0)
    acc(HOST, 4'hB, 1'h0, MPC, 32'h0);
    `CHK(resp, REF)
    acc(2'h3, 4'h0, 1'h0, MPC, 32'h0);
    `CHK(resp, REF)
  endtask : t_straps

  // loader reaches read-only bits; port mask writes keep only the writable bits
  task automatic t_load();
    acc(EE, 4'h0, 1'h1, MPC, 32'hFFFF_C03B);
    acc(EE, 4'h0, 1'h0, MPC, 32'h0);
    `CHK(rd, 32'h0000_C033)
    acc(EE, 4'h0, 1'h1, vsir_pkg::PUS_BASE, 32'h0000_00FB);
    acc(EE, 4'h0, 1'h1, vsir_pkg::PUS_LAST, 32'h0000_0016);
    acc(EE, 4'h0, 1'h1, vsir_pkg::PPM_BASE, 32'h00FF_FFFF);
    acc(EE, 4'h0, 1'h0, vsir_pkg::PPM_BASE, 32'h0);
    `CHK(rd, 32'h00FF_000F)
    i_vsir_agent.set_done(1'h1);
    cyc(3);
    `CHK(mgmt_train, 1'h1)
    `CHK(link_train, 1'h0)
    acc(EE, 4'h0, 1'h0, MPC, 32'h0);
    `CHK(resp, REF)
  endtask : t_load

  task automatic t_mgmt();
    acc(HOST, 4'h3, 1'h0, PEN, 32'h0);
    `CHK(resp, REF)
    acc(HOST, 4'hB, 1'h1, MPC, 32'h0000_0033);
    acc(HOST, 4'hB, 1'h0, MPC, 32'h0);
    `CHK(rd, 32'h0000_C033)
    acc(I2C, 4'h0, 1'h0, MPC, 32'h0);
    `CHK(resp, REF)
    acc(HOST, 4'hB, 1'h1, PEN, 32'hFFFF_FFF5);
    acc(HOST, 4'hB, 1'h0, PEN, 32'h0);
    `CHK(rd, 32'h0000_0005)
    acc(HOST, 4'hB, 1'h1, REL, 32'hFFFF_FFFE);
    cyc(3);
    `CHK(link_train, 1'h0)
    acc(HOST, 4'hB, 1'h1, REL, 32'h0000_0001);
    cyc(2);
    `CHK(link_train, 1'h1)
    `CHK(released, 1'h1)
    `CHK(part_active, 4'h5)
    `CHK(part_up[31:0], 32'h0000_0013)
    `CHK(part_up[127:96], 32'h0000_0000)
    `CHK(part_mask[31:0], 32'h00FF_000F)
    acc(HOST, 4'h3, 1'h1, REL, 32'h0000_0001);
    `CHK(resp, REF)
  endtask : t_mgmt

  task automatic t_hot();
    hot_rst_in = 1'h1;
    cyc(1);
    hot_rst_in = 1'h0;
    cyc(3);
    `CHK(mgmt_train, 1'h1)
    `CHK(link_train, 1'h0)
    acc(HOST, 4'hB, 1'h0, MPC, 32'h0);
    `CHK(rd, 32'h0000_C033)
    acc(HOST, 4'hB, 1'h1, PEN, 32'h0);
    `CHK(resp, ACK)
    `CHK(vs_mode, 1'h1)
    // host B names port 5 redundant; port 5 then takes over as active
    acc(HOST, 4'h5, 1'h0, PEN, 32'h0);
    `CHK(resp, REF)
    acc(HOST, 4'hB, 1'h1, MPC, 32'h0000_2533);
    `CHK(resp, ACK)
    acc(HOST, 4'h5, 1'h1, MPC, 32'h0000_0025);
    `CHK(resp, ACK)
    acc(HOST, 4'h5, 1'h0, MPC, 32'h0);
    `CHK(rd, 32'h0000_C025)
    acc(HOST, 4'hB, 1'h0, PEN, 32'h0);
    `CHK(resp, REF)
    acc(HOST, 4'h5, 1'h0, PEN, 32'h0);
    `CHK(resp, ACK)
  endtask : t_hot

  // base mode, i2c configures, no management port
  task automatic t_i2c();
    do_reset(2'h0, 1'h1, 1'h0, 1'h0, 4'h0);
    `CHK(vs_mode, 1'h0)
    acc(EE, 4'h0, 1'h1, PEN, 32'h0000_000F);
    `CHK(resp, REF)
    i_vsir_agent.set_done(1'h1);
    cyc(3);
    `CHK(link_train, 1'h0)
    acc(HOST, 4'h0, 1'h0, MPC, 32'h0);
    `CHK(resp, REF)
    acc(I2C, 4'h0, 1'h0, MPC, 32'h0);
    `CHK(resp, ACK)
    `CHK(rd, 32'h0000_0000)
    acc(I2C, 4'h0, 1'h0, PEN, 32'h0);
    `CHK(resp, REF)
    i_vsir_agent.wait_gap();
    acc(I2C, 4'h0, 1'h1, REL, 32'h0000_0001);
    `CHK(resp, ACK)
    cyc(2);
    `CHK(link_train, 1'h1)
  endtask : t_i2c

  task automatic t_opt2();
    do_reset(2'h1, 1'h0, 1'h1, 1'h1, 4'h0);
    `CHK(link_train, 1'h0)
    i_vsir_agent.set_done(1'h1);
    cyc(3);
    `CHK(link_train, 1'h1)
    `CHK(part_active, 4'h3)
  endtask : t_opt2

  initial begin
    sys_rst_in = 1'h1;
    hot_rst_in = 1'h0;
    mode = 2'h0;
    en_n = 1'h1;
    opt = 1'h0;
    i2c_n = 1'h1;
    sel = 4'h0;
    do_reset(2'h2, 1'h0, 1'h0, 1'h1, 4'hB);
    t_straps();
    t_load();
    t_mgmt();
    t_hot();
    t_i2c();
    t_opt2();
    give_verdict();
  end
endmodule : virtual_switch_init_release_bench
